// ---- hdl/serial_unit_pkg.sv ----
// Constants shared by the serial unit status and error handling block.
// Assumes one 40 MHz peripheral clock; link pins arrive asynchronously.
//
// Operation
// - Slave sets stop-detect flag on stop or repeated start and restarts process.
// - Slave-selected flag clears on stop or repeated start.
// - SPI master reports transmit-empty and receive-full flags, no busy flag.
// - Clearing slave operation-done flag returns slave status to zero.
// - Stop is honoured only in permitted slave modes, then status reads 0x1.
// - A second byte received while buffer unread raises the mode's overrun flag.
// - I2C overrun recovery: clear flag, read buffer twice, overrun state ends.
// - UART overrun ignores writes; only writing mode zero clears it.
// - Masked error causes still set flags but raise no request.
// - Slave operation starts one clock after its trigger is written.
// - Unit pins are held low in the initial state.
package serial_unit_pkg;

    // Interface modes
    typedef enum logic [2:0] {
        MODE_OFF    = 3'h0,
        MODE_UART   = 3'h1,
        MODE_SPI    = 3'h2,
        MODE_I2C_M  = 3'h3,
        MODE_I2C_S  = 3'h4
    } iface_mode_e;

    localparam logic [2:0] MODE_RESET      = 3'h0;

    // Slave operation modes and status codes
    localparam logic [2:0] SOP_TX_DATA     = 3'h2;
    localparam logic [2:0] SOP_RX_DATA     = 3'h4;
    localparam logic [2:0] SOP_ACK_RX      = 3'h6;
    localparam logic [2:0] SOP_STS_CLEAR   = 3'h0;
    localparam logic [2:0] SOP_STS_STOP    = 3'h1;
    localparam logic [2:0] SOP_STS_DONE    = 3'h2;

    // Data path
    localparam int         DATA_W          = 8;
    localparam int         FIFO_DEPTH      = 8;
    localparam int         BIT_CNT_W       = 3;
    localparam logic [2:0] BIT_LAST        = 3'h7;
    localparam logic [2:0] BIT_FIRST       = 3'h0;

endpackage : serial_unit_pkg

// ---- hdl/serial_fifo.sv ----
// Parameterised first-in first-out buffer for received bytes.
// Assumes one clock and a synchronous, already released reset.
`timescale 1ns/100ps
module serial_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             i_clock,
    input  wire logic             i_rstn,
    input  wire logic             i_flush,
    input  wire logic [WIDTH-1:0] i_in_data,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    output logic [WIDTH-1:0]      o_out_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [$clog2(DEPTH):0] o_count
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q;
    logic [PW-1:0]    rd_q;
    logic [PW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign o_in_ready  = (cnt_q != DEPTH[PW:0]);
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data  = mem_q[rd_q];
    assign o_count     = cnt_q;
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    // Storage
    always_ff @(posedge i_clock) begin
        if (push) begin
            mem_q[wr_q] <= i_in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (i_flush) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
        end
    end

    // A byte accepted with no pop or flush in the same cycle raises the count by one
    property p_count_up;
        @(posedge i_clock) disable iff (!i_rstn)
        (push && !pop && !i_flush) |=> (cnt_q == $past(cnt_q) + 1'b1);
    endproperty
    a_count_up: assert property (p_count_up) else $error("fifo count slipped");
endmodule : serial_fifo

// ---- hdl/serial_unit_status.sv ----
// Status, error flags and sequencing of the multi-mode serial unit.
// Assumes link pins are asynchronous and pass two flip-flops before use;
// software-side strobes are one-cycle pulses on i_clock.
`timescale 1ns/100ps
module serial_unit_status
(
    input  wire logic                       i_clock,
    input  wire logic                       i_rstn,
    // Software side
    input  wire logic                       i_mode_wr,
    input  wire logic [2:0]                 i_mode_data,
    input  wire logic                       i_rx_read,
    input  wire logic                       i_ovr_clear,
    input  wire logic                       i_uart_ovr_wr,
    input  wire logic                       i_err_irq_en,
    input  wire logic                       i_slave_trig,
    input  wire logic [2:0]                 i_slave_op_mode,
    input  wire logic                       i_slave_done_clr,
    input  wire logic                       i_spi_tx_write,
    input  wire logic                       i_stop_flag_clr,
    // Link side
    input  wire logic                       i_link_clk,
    input  wire logic                       i_link_data,
    input  wire logic                       i_link_sda,
    input  wire logic                       i_link_addr_hit,
    // Outputs
    output logic [2:0]                      o_mode,
    output logic [serial_unit_pkg::DATA_W-1:0] o_rx_data,
    output logic                            o_rx_valid,
    output logic                            o_spi_tx_empty_flag,
    output logic                            o_spi_rx_full_flag,
    output logic                            o_spi_overrun_flag,
    output logic                            o_i2c_master_overrun_flag,
    output logic                            o_i2c_slave_overrun_flag,
    output logic                            o_uart_overrun_flag,
    output logic                            o_stop_detect_flag,
    output logic                            o_slave_selected,
    output logic [2:0]                      o_slave_op_status,
    output logic                            o_slave_op_done_flag,
    output logic                            o_slave_busy,
    output logic                            o_err_irq,
    output logic                            o_pin_out,
    output logic                            o_pin_oe
);
    import serial_unit_pkg::*;

    //--------------------------------------------------------------
    // Reset release and input synchronisers
    //--------------------------------------------------------------
    logic       rst_s1_q;
    logic       rst_n;
    logic [2:0] clk_sync_q;
    logic [1:0] dat_sync_q;
    logic [2:0] sda_sync_q;
    logic [1:0] hit_sync_q;

    // Reset released through two flops
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // Link pins, two stages; link clock and sda add a history flop for edge detection
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            clk_sync_q <= '0;
            dat_sync_q <= '0;
            sda_sync_q <= '0;
            hit_sync_q <= '0;
        end else begin
            clk_sync_q <= {clk_sync_q[1:0], i_link_clk};
            dat_sync_q <= {dat_sync_q[0], i_link_data};
            sda_sync_q <= {sda_sync_q[1:0], i_link_sda};
            hit_sync_q <= {hit_sync_q[0], i_link_addr_hit};
        end
    end

    logic clk_rise;
    logic sda_fall;
    logic sda_rise;
    logic scl_high;
    logic bus_start;
    logic bus_stop;
    assign clk_rise  = clk_sync_q[1] && !clk_sync_q[2];
    assign scl_high  = clk_sync_q[1] && clk_sync_q[2];
    assign sda_fall  = !sda_sync_q[1] && sda_sync_q[2];
    assign sda_rise  = sda_sync_q[1] && !sda_sync_q[2];
    assign bus_start = scl_high && sda_fall;
    assign bus_stop  = scl_high && sda_rise;

    //--------------------------------------------------------------
    // Mode register
    //--------------------------------------------------------------
    logic [2:0] mode_q;
    logic       reinit;
    logic       is_i2c;
    assign reinit = i_mode_wr && (i_mode_data == MODE_RESET);
    assign is_i2c = (mode_q == MODE_I2C_M) || (mode_q == MODE_I2C_S);

    // Software-selected interface mode
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= MODE_RESET;
        end else if (i_mode_wr) begin
            mode_q <= i_mode_data;
        end
    end

    //--------------------------------------------------------------
    // Receive shifter
    //--------------------------------------------------------------
    logic [DATA_W-1:0]    shift_q;
    logic [BIT_CNT_W-1:0] bit_q;
    logic                 byte_done;
    logic                 frame_start;
    assign frame_start = bus_start || reinit;
    assign byte_done   = clk_rise && (bit_q == BIT_LAST) && (mode_q != MODE_OFF);

    // Shift data in on each link clock rising edge while the mode is not off
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= '0;
            bit_q   <= BIT_FIRST;
        end else if (frame_start || (is_i2c && bus_stop)) begin
            bit_q   <= BIT_FIRST;
        end else if (clk_rise && mode_q != MODE_OFF) begin
            shift_q <= {shift_q[DATA_W-2:0], dat_sync_q[1]};
            bit_q   <= bit_q + 1'b1;
        end
    end

    //--------------------------------------------------------------
    // Receive buffer and overrun detection
    //--------------------------------------------------------------
    logic                       fifo_in_ready;
    logic                       fifo_out_valid;
    logic [DATA_W-1:0]          fifo_out_data;
    logic [$clog2(FIFO_DEPTH):0] fifo_count;
    logic                       second_unread;
    logic                       ovr_event;

    // Both old and new bytes are kept so two reads drain it
    serial_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .i_clock     (i_clock),
        .i_rstn      (rst_n),
        .i_flush     (reinit),
        .i_in_data   ({shift_q[DATA_W-2:0], dat_sync_q[1]}),
        .i_in_valid  (byte_done),
        .o_in_ready  (fifo_in_ready),
        .o_out_data  (fifo_out_data),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (i_rx_read),
        .o_count     (fifo_count)
    );

    // A second byte while the first is still unread is an overrun
    assign second_unread = fifo_out_valid && !(i_rx_read && fifo_count == 1);
    assign ovr_event     = byte_done && (second_unread || !fifo_in_ready);

    // Overrun flags; hardware set wins over software clear, except UART where reinit wins
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_spi_overrun_flag        <= 1'b0;
            o_i2c_master_overrun_flag <= 1'b0;
            o_i2c_slave_overrun_flag  <= 1'b0;
            o_uart_overrun_flag       <= 1'b0;
        end else begin
            if (reinit) begin
                o_uart_overrun_flag <= 1'b0;
            end else if (ovr_event && mode_q == MODE_UART) begin
                o_uart_overrun_flag <= 1'b1;      // writes to it are ignored
            end
            if (ovr_event && mode_q == MODE_SPI) begin
                o_spi_overrun_flag <= 1'b1;
            end else if (i_ovr_clear || reinit) begin
                o_spi_overrun_flag <= 1'b0;
            end
            if (ovr_event && mode_q == MODE_I2C_M) begin
                o_i2c_master_overrun_flag <= 1'b1;
            end else if (i_ovr_clear || reinit) begin
                o_i2c_master_overrun_flag <= 1'b0;
            end
            if (ovr_event && mode_q == MODE_I2C_S) begin
                o_i2c_slave_overrun_flag <= 1'b1;
            end else if (i_ovr_clear || reinit) begin
                o_i2c_slave_overrun_flag <= 1'b0;
            end
        end
    end

    // Error request gated by enable; flags still set
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_err_irq <= 1'b0;
        end else begin
            o_err_irq <= i_err_irq_en && (o_spi_overrun_flag || o_uart_overrun_flag
                         || o_i2c_master_overrun_flag || o_i2c_slave_overrun_flag);
        end
    end

    // Registered read data
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_rx_data  <= '0;
            o_rx_valid <= 1'b0;
        end else begin
            o_rx_data  <= fifo_out_data;
            o_rx_valid <= fifo_out_valid;
        end
    end

    //--------------------------------------------------------------
    // SPI transfer-control flags
    //--------------------------------------------------------------
    // Transmit-empty and receive-full replace any busy flag
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_spi_tx_empty_flag <= 1'b1;
            o_spi_rx_full_flag  <= 1'b0;
        end else begin
            if (byte_done && mode_q == MODE_SPI) begin
                o_spi_tx_empty_flag <= 1'b1;
            end else if (i_spi_tx_write) begin
                o_spi_tx_empty_flag <= 1'b0;
            end
            o_spi_rx_full_flag <= (mode_q == MODE_SPI) && fifo_out_valid;
        end
    end

    //--------------------------------------------------------------
    // I2C slave bus conditions and operation sequencing
    //--------------------------------------------------------------
    logic stop_or_rs;
    logic stop_allowed;
    logic trig_q;
    assign stop_or_rs   = (mode_q == MODE_I2C_S) && (bus_stop || (bus_start && o_slave_busy));
    assign stop_allowed = (i_slave_op_mode == SOP_RX_DATA) || (i_slave_op_mode == SOP_TX_DATA)
                          || (i_slave_op_mode == SOP_ACK_RX);

    // Stop-detect and selected flags
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_stop_detect_flag <= 1'b0;
            o_slave_selected   <= 1'b0;
        end else begin
            if (stop_or_rs) begin
                o_stop_detect_flag <= 1'b1;
            end else if (i_stop_flag_clr) begin
                o_stop_detect_flag <= 1'b0;
            end
            if (stop_or_rs) begin
                o_slave_selected <= 1'b0;
            end else if (hit_sync_q[1] && mode_q == MODE_I2C_S) begin
                o_slave_selected <= 1'b1;
            end
        end
    end

    // Trigger delay: operation starts one clock after the write
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            trig_q       <= 1'b0;
            o_slave_busy <= 1'b0;
        end else begin
            trig_q <= i_slave_trig && (mode_q == MODE_I2C_S);
            if (trig_q) begin
                o_slave_busy <= 1'b1;
            end else if (stop_or_rs || byte_done) begin
                o_slave_busy <= 1'b0;
            end
        end
    end

    // Operation status and done flag
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_slave_op_status    <= SOP_STS_CLEAR;
            o_slave_op_done_flag <= 1'b0;
        end else if (o_slave_busy && stop_or_rs && stop_allowed) begin
            o_slave_op_status    <= SOP_STS_STOP;
            o_slave_op_done_flag <= 1'b1;
        end else if (o_slave_busy && byte_done && mode_q == MODE_I2C_S) begin
            o_slave_op_status    <= SOP_STS_DONE;
            o_slave_op_done_flag <= 1'b1;
        end else if (i_slave_done_clr) begin
            o_slave_op_status    <= SOP_STS_CLEAR;
            o_slave_op_done_flag <= 1'b0;
        end
    end

    //--------------------------------------------------------------
    // Pins and mode output
    //--------------------------------------------------------------
    // Pins held low in every mode except UART
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_pin_out <= 1'b0;
            o_pin_oe  <= 1'b1;
            o_mode    <= MODE_RESET;
        end else begin
            o_pin_out <= (mode_q == MODE_UART);
            o_pin_oe  <= 1'b1;
            o_mode    <= mode_q;
        end
    end

    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------
    property p_trig_delay;
        @(posedge i_clock) disable iff (!rst_n)
        (i_slave_trig && mode_q == MODE_I2C_S && !o_slave_busy) |=> ##1 o_slave_busy;
    endproperty
    a_trig_delay: assert property (p_trig_delay) else $error("slave start late");

    property p_stop_flag;
        @(posedge i_clock) disable iff (!rst_n) stop_or_rs |=> o_stop_detect_flag;
    endproperty
    a_stop_flag: assert property (p_stop_flag) else $error("stop flag missed");

    property p_sel_clear;
        @(posedge i_clock) disable iff (!rst_n) stop_or_rs |=> !o_slave_selected;
    endproperty
    a_sel_clear: assert property (p_sel_clear) else $error("selected kept");

    property p_done_clr;
        @(posedge i_clock) disable iff (!rst_n)
        (i_slave_done_clr && !o_slave_busy) |=> (o_slave_op_status == SOP_STS_CLEAR);
    endproperty
    a_done_clr: assert property (p_done_clr) else $error("status not cleared");

    property p_stop_status;
        @(posedge i_clock) disable iff (!rst_n)
        (o_slave_busy && stop_or_rs && stop_allowed) |=> (o_slave_op_status == SOP_STS_STOP);
    endproperty
    a_stop_status: assert property (p_stop_status) else $error("stop status wrong");

    property p_ovr_set;
        @(posedge i_clock) disable iff (!rst_n)
        (ovr_event && mode_q == MODE_I2C_S) |=> o_i2c_slave_overrun_flag;
    endproperty
    a_ovr_set: assert property (p_ovr_set) else $error("overrun missed");

    property p_uart_hold;
        @(posedge i_clock) disable iff (!rst_n)
        (o_uart_overrun_flag && !reinit) |=> o_uart_overrun_flag;
    endproperty
    a_uart_hold: assert property (p_uart_hold) else $error("uart overrun lost");

    property p_irq_mask;
        @(posedge i_clock) disable iff (!rst_n) !i_err_irq_en |=> !o_err_irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked request");

    property p_rx_full;
        @(posedge i_clock) disable iff (!rst_n)
        (mode_q == MODE_SPI && fifo_out_valid) |=> o_spi_rx_full_flag;
    endproperty
    a_rx_full: assert property (p_rx_full) else $error("rx full missed");

    c_overrun:  cover property (@(posedge i_clock) disable iff (!rst_n) ovr_event);
    c_stop:     cover property (@(posedge i_clock) disable iff (!rst_n) stop_or_rs);
    c_slave_op: cover property (@(posedge i_clock) disable iff (!rst_n) trig_q ##[1:300] byte_done);
endmodule : serial_unit_status

// ---- test/serial_far_model.sv ----
// Behavioural far-side serial device driving the unit's link pins.
// Assumes the unit samples these pins with its own clock; link period 200 ns.
`timescale 1ns/100ps
module serial_far_model (
    output logic o_link_clk,
    output logic o_link_data,
    output logic o_link_sda,
    output logic o_link_addr_hit
);
    // Clock stands low between frames, sda idles high on its pull-up
    initial begin
        o_link_clk      = 1'b0;
        o_link_data     = 1'b0;
        o_link_sda      = 1'b1;
        o_link_addr_hit = 1'b0;
    end
    // One byte, MSB first, data changes only while the clock is low
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            o_link_data = b[i];
            #100 o_link_clk = 1'b1;
            #100 o_link_clk = 1'b0;
        end
        o_link_data = ~b[0]; // Released line shows no stale bit
    endtask : send_byte
    // Stop condition: sda rises while the clock is high
    task automatic stop_cond();
        o_link_sda = 1'b0;
        #100 o_link_clk = 1'b1;
        #100 o_link_sda = 1'b1;
        #100 o_link_clk = 1'b0;
    endtask : stop_cond
endmodule : serial_far_model

// ---- test/serial_unit_status_tb.sv ----
// Self-checking bench for the serial unit status block.
// Assumes the far-side model drives the link; software strobes come from here.
`timescale 1ns/100ps
module serial_unit_status_tb;
    import serial_unit_pkg::*;
    logic       i_clock, i_rstn, mode_wr, rx_read, ovr_clr, uovr_wr, irq_en, trig;
    logic       done_clr, tx_wr, stop_clr, lclk, ldata, lsda, lhit;
    logic [2:0] mode_val, sop_mode, mode, status;
    logic [7:0] rx_data;
    logic       rx_valid, tx_empty, rx_full, spi_ovr, im_ovr, is_ovr, u_ovr;
    logic       stop_f, sel, done_f, busy, irq, pin, pin_oe;
    int         failures, checks_done;

    serial_far_model u_far (.o_link_clk(lclk), .o_link_data(ldata), .o_link_sda(lsda),
        .o_link_addr_hit(lhit));
    serial_unit_status u_dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_mode_wr(mode_wr),
        .i_mode_data(mode_val), .i_rx_read(rx_read), .i_ovr_clear(ovr_clr),
        .i_uart_ovr_wr(uovr_wr), .i_err_irq_en(irq_en), .i_slave_trig(trig),
        .i_slave_op_mode(sop_mode), .i_slave_done_clr(done_clr), .i_spi_tx_write(tx_wr),
        .i_stop_flag_clr(stop_clr), .i_link_clk(lclk), .i_link_data(ldata),
        .i_link_sda(lsda), .i_link_addr_hit(lhit), .o_mode(mode), .o_rx_data(rx_data),
        .o_rx_valid(rx_valid), .o_spi_tx_empty_flag(tx_empty), .o_spi_rx_full_flag(rx_full),
        .o_spi_overrun_flag(spi_ovr), .o_i2c_master_overrun_flag(im_ovr),
        .o_i2c_slave_overrun_flag(is_ovr), .o_uart_overrun_flag(u_ovr),
        .o_stop_detect_flag(stop_f), .o_slave_selected(sel), .o_slave_op_status(status),
        .o_slave_op_done_flag(done_f), .o_slave_busy(busy), .o_err_irq(irq),
        .o_pin_out(pin), .o_pin_oe(pin_oe));

    // -----------------------------------------------------------------
    // Clock, helpers and access tasks
    // -----------------------------------------------------------------
    initial begin
        i_clock = 1'b0;
        forever #12.5 i_clock = ~i_clock;
    end
    task automatic step();
        @(posedge i_clock);
        #1;
    endtask : step
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask : chk_byte
    task automatic chk_bit(input logic got, input logic exp, input string what);
        chk_byte({7'h00, got}, {7'h00, exp}, what);
    endtask : chk_bit
    // Overrun flag that belongs to an SPI or I2C mode
    function automatic logic ovr_of(input logic [2:0] m);
        return (m == MODE_SPI) ? spi_ovr : (m == MODE_I2C_M) ? im_ovr : is_ovr;
    endfunction : ovr_of
    task automatic set_mode(input logic [2:0] m);
        step();
        mode_val = m;
        mode_wr  = 1'b1;
        step();
        mode_wr  = 1'b0;
    endtask : set_mode
    task automatic read_rx();
        step();
        rx_read = 1'b1;
        step();
        rx_read = 1'b0;
        repeat (3) step();
    endtask : read_rx
    task automatic give_verdict();
        if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    // Two unread bytes overrun, then clear and drain with two reads
    task automatic ovr_case(input logic [2:0] m, input logic [7:0] a, input logic [7:0] b);
        set_mode(m);
        tx_wr = (m == MODE_SPI);
        step();
        tx_wr = 1'b0;
        step();
        if (m == MODE_SPI) chk_bit(tx_empty, 1'b0, "tx written");
        u_far.send_byte(a);
        repeat (10) step();
        if (m == MODE_SPI) chk_bit(rx_full, 1'b1, "rx full");
        if (m == MODE_SPI) chk_bit(tx_empty, 1'b1, "tx empty again");
        u_far.send_byte(b);
        repeat (10) step();
        chk_bit(ovr_of(m), 1'b1, "overrun set");
        chk_bit(irq, 1'b0, "masked request");
        irq_en = 1'b1;
        repeat (2) step();
        chk_bit(irq, 1'b1, "request raised");
        irq_en = 1'b0;
        step();
        ovr_clr = 1'b1;
        step();
        ovr_clr = 1'b0;
        step();
        chk_bit(ovr_of(m), 1'b0, "overrun cleared");
        chk_byte(rx_data, a, "older byte");
        read_rx();
        chk_byte(rx_data, b, "newer byte");
        read_rx();
        chk_bit(rx_valid, 1'b0, "path drained");
    endtask : ovr_case

    // -----------------------------------------------------------------
    // Main sequence and hang guard
    // -----------------------------------------------------------------
    initial begin
        {i_rstn, mode_wr, rx_read, ovr_clr, uovr_wr, irq_en, trig} = '0;
        {done_clr, tx_wr, stop_clr, mode_val, sop_mode} = '0;
        failures = 0;
        checks_done = 0;
        repeat (12) @(posedge i_clock);
        #1 i_rstn = 1'b1;
        repeat (4) step();
        chk_bit(pin, 1'b0, "pin low");
        chk_bit(pin_oe, 1'b1, "pin driven");
        chk_bit(tx_empty, 1'b1, "tx empty");
        ovr_case(MODE_SPI, 8'hA5, 8'h3C);
        ovr_case(MODE_I2C_M, 8'h81, 8'h7E);
        ovr_case(MODE_I2C_S, 8'h1E, 8'hE1);
        // UART overrun survives a write, only reinit clears it
        set_mode(MODE_UART);
        u_far.send_byte(8'h5A);
        u_far.send_byte(8'hC3);
        repeat (10) step();
        chk_bit(u_ovr, 1'b1, "uart overrun");
        chk_bit(pin, 1'b1, "uart line idles high");
        uovr_wr = 1'b1;
        step();
        uovr_wr = 1'b0;
        step();
        chk_bit(u_ovr, 1'b1, "write ignored");
        set_mode(MODE_OFF);
        step();
        chk_bit(u_ovr, 1'b0, "reinit clears");
        chk_byte({5'h00, mode}, {5'h00, MODE_OFF}, "mode zero");
        // Slave trigger, stop detection and status clearing
        set_mode(MODE_I2C_S);
        sop_mode = SOP_ACK_RX;
        step();
        trig = 1'b1;
        step();
        trig = 1'b0;
        chk_bit(busy, 1'b0, "not yet busy");
        step();
        chk_bit(busy, 1'b1, "busy");
        u_far.o_link_addr_hit = 1'b1;
        u_far.send_byte(8'h52);
        u_far.o_link_addr_hit = 1'b0;
        repeat (10) step();
        chk_bit(sel, 1'b1, "selected");
        chk_byte({5'h00, status}, {5'h00, SOP_STS_DONE}, "byte done status");
        chk_byte(rx_data, 8'h52, "slave byte");
        read_rx();
        // Acknowledge step is triggered only after the byte was read
        done_clr = 1'b1;
        step();
        done_clr = 1'b0;
        chk_byte({5'h00, status}, {5'h00, SOP_STS_CLEAR}, "status zeroed");
        trig = 1'b1;
        step();
        trig = 1'b0;
        step();
        chk_bit(busy, 1'b1, "ack step busy");
        u_far.stop_cond();
        repeat (10) step();
        chk_bit(stop_f, 1'b1, "stop seen");
        chk_bit(busy, 1'b0, "process reset");
        chk_byte({5'h00, status}, {5'h00, SOP_STS_STOP}, "stop status");
        chk_bit(done_f, 1'b1, "stop done flag");
        chk_bit(sel, 1'b0, "deselected");
        done_clr = 1'b1;
        step();
        done_clr = 1'b0;
        step();
        chk_byte({5'h00, status}, {5'h00, SOP_STS_CLEAR}, "status cleared");
        chk_bit(done_f, 1'b0, "done flag cleared");
        stop_clr = 1'b1;
        step();
        stop_clr = 1'b0;
        step();
        chk_bit(stop_f, 1'b0, "stop flag cleared");
        give_verdict();
    end
    initial begin
        #2000000;
        failures++;
        give_verdict();
    end
endmodule : serial_unit_status_tb
